// ===== timer_sync_pwm_modes_bench.sv
// Self-checking bench for the synchronized and PWM timer block
module timer_sync_pwm_modes_bench import tsp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [4:0] start_bits = '0, sync_sel = '0, pwm_mode = '0, count_wr = '0;
   logic [9:0] clr_src = '0, edge_sel = '0, io_a = '0, io_b = '0;
   logic [14:0] psc_sel = '0;
   logic [79:0] general_reg_a = '0, general_reg_b = '0;
   logic [15:0] wdata = '0;
   logic [1:0] combo = '0;
   logic [3:0] ext_clk = '0;
   logic [4:0] pin_a, pin_a_oe, pin_b, pin_b_oe;
   logic aux_a4, aux_b4, aux_oe, rsync;
   logic [79:0] cnt_all;
   int bad_count = 0;
   int n_checks = 0;

   // Prescaler and external clocks stay at system rate to keep runs short, except in the last scenario, which checks the divided and external clocks
   tsp_top tsp_top_inst (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_start_bits(start_bits),
      .i_sync_select_reg(sync_sel), .i_timer_mode_pwm(pwm_mode), .i_clear_source_field(clr_src),
      .i_clock_prescale_select(psc_sel), .i_ext_edge_select(edge_sel), .i_pin_a_io_field(io_a),
      .i_pin_b_io_field(io_b), .i_general_reg_a(general_reg_a), .i_general_reg_b(general_reg_b), .i_count_wr(count_wr),
      .i_count_wdata(wdata), .i_combo_mode_field(combo), .i_ext_clk(ext_clk), .o_chan_pin_a(pin_a),
      .o_chan_pin_a_oe(pin_a_oe), .o_chan_pin_b(pin_b), .o_chan_pin_b_oe(pin_b_oe), .o_aux_out_a4(aux_a4),
      .o_aux_out_b4(aux_b4), .o_aux_oe(aux_oe), .o_timer_count(cnt_all), .o_rsync_active(rsync));

   // 100 ns system clock
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [15:0] cnt_of(input int ch);
      return cnt_all[ch*16 +: 16];
   endfunction

   // Every scenario starts from a clean reset so pin history cannot leak across
   task automatic do_reset(input int n);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      {start_bits, sync_sel, pwm_mode, count_wr, clr_src, io_a, io_b, general_reg_a, general_reg_b, wdata, combo} <= '0;
      {psc_sel, edge_sel, ext_clk} <= '0;
      repeat (n) @(posedge clk_sys);
      reset_n <= 1'b1;
   endtask

   // One channel in PWM mode against a small reference of counter and pins
   task automatic pwm_run(input int ch, input logic [15:0] a, input logic [15:0] b, input logic [1:0] clr);
      logic [15:0] mc;
      logic mp, mb, ha, hb;
      mc = '0;
      mp = 1'b0;
      mb = 1'b0;
      do_reset(2);
      @(posedge clk_sys);
      general_reg_a[ch*16 +: 16] <= a;
      general_reg_b[ch*16 +: 16] <= b;
      clr_src[ch*2 +: 2] <= clr;
      io_a[ch*2 +: 2] <= TSP_IO_ZERO;
      // Channel 1 drives pin B low on match so the zero action is exercised in PWM mode
      io_b[ch*2 +: 2] <= (ch == 1) ? TSP_IO_ZERO : TSP_IO_TOGGLE;
      pwm_mode[ch] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk16("halted count", 16'h0000, cnt_of(ch));
      chk1("pin a enable", 1'b1, pin_a_oe[ch]);
      chk1("pin b enable", 1'b1, pin_b_oe[ch]);
      @(posedge clk_sys);
      start_bits[ch] <= 1'b1;
      for (int k = 0; k < 14; k++) begin
         @(posedge clk_sys);
         ha = (mc == a);
         hb = (mc == b);
         if (ha && !hb) mp = 1'b1;
         if (hb && !ha) mp = 1'b0;
         if (hb) mb = (ch == 1) ? 1'b0 : ~mb;
         mc = ((clr == TSP_CLR_GRA && ha) || (clr == TSP_CLR_GRB && hb)) ? 16'h0000 : mc + 16'h0001;
         @(negedge clk_sys);
         chk16("pwm count", mc, cnt_of(ch));
         chk1("pwm pin a", mp, pin_a[ch]);
         chk1("pwm pin b", mb, pin_b[ch]);
      end
   endtask

   // Hang guard: a stuck run still reaches the verdict
   initial begin
      #3000000;
      bad_count++;
      complete_run();
   end

   initial begin
      logic [15:0] mc, mc4;
      logic o1, o2, o3, hc;
      do_reset(12);
      @(negedge clk_sys);
      chk16("reset count", 16'h0000, cnt_of(3));
      chk1("reset aux enable", 1'b0, aux_oe);
      // Plain duty, equal registers, 0 and 100 percent, one per channel
      pwm_run(0, 16'h0002, 16'h0004, TSP_CLR_GRB);
      pwm_run(1, 16'h0003, 16'h0003, TSP_CLR_GRB);
      pwm_run(2, 16'h0006, 16'h0004, TSP_CLR_GRB);
      pwm_run(3, 16'h0002, 16'h0006, TSP_CLR_GRA);
      pwm_run(4, 16'h0005, 16'h0001, TSP_CLR_GRA);
      // Sync preset into channels 0..2, channel 3 stays out, then sync clear
      do_reset(2);
      @(posedge clk_sys);
      sync_sel <= 5'h07;
      count_wr <= 5'h02;
      wdata <= 16'h1234;
      general_reg_b[15:0] <= 16'h1236;
      clr_src <= {TSP_CLR_NONE, TSP_CLR_NONE, TSP_CLR_NONE, TSP_CLR_SYNC, TSP_CLR_GRB};
      @(posedge clk_sys);
      count_wr <= 5'h00;
      start_bits <= 5'h07;
      @(negedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         chk16("preset count", (i < 3) ? 16'h1234 : 16'h0000, cnt_of(i));
      end
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk16("own clear count", 16'h0000, cnt_of(0));
      chk16("sync clear count", 16'h0000, cnt_of(1));
      chk16("no clear count", 16'h1237, cnt_of(2));
      // Reset-synchronized PWM entered while channel 3 is halted
      do_reset(2);
      @(posedge clk_sys);
      combo <= TSP_COMBO_RSYNC;
      general_reg_a[63:48] <= 16'h0009;
      general_reg_b[63:48] <= 16'h0003;
      general_reg_a[79:64] <= 16'h0005;
      general_reg_b[79:64] <= 16'h0007;
      clr_src[9:8] <= TSP_CLR_GRA;
      start_bits[4] <= 1'b1;
      @(posedge clk_sys);
      start_bits[3] <= 1'b1;
      @(negedge clk_sys);
      chk1("mode active", 1'b1, rsync);
      chk1("aux enable", 1'b1, aux_oe);
      mc = '0;
      // Channel 4 took one step at the edge that latched the mode
      mc4 = 16'h0001;
      {o1, o2, o3} = 3'h0;
      for (int k = 0; k < 22; k++) begin
         @(posedge clk_sys);
         hc = (mc == 16'h0009);
         if ((mc == 16'h0003) != hc) o1 = ~o1;
         if ((mc == 16'h0005) != hc) o2 = ~o2;
         if ((mc == 16'h0007) != hc) o3 = ~o3;
         mc = hc ? 16'h0000 : mc + 16'h0001;
         mc4 = mc4 + 16'h0001;
         @(negedge clk_sys);
         chk16("period count", mc, cnt_of(3));
         chk16("free count", mc4, cnt_of(4));
         chk1("out1", o1, pin_a[3]);
         chk1("out1 inverse", ~o1, pin_b[3]);
         chk1("out2", o2, pin_a[4]);
         chk1("out2 inverse", ~o2, aux_a4);
         chk1("out3", o3, pin_b[4]);
         chk1("out3 inverse", ~o3, aux_b4);
      end
      // Mode change is ignored while channel 3 runs, taken once it halts
      @(posedge clk_sys);
      combo <= 2'h0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk1("mode held running", 1'b1, rsync);
      @(posedge clk_sys);
      start_bits[3] <= 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk1("mode left", 1'b0, rsync);
      chk1("aux released", 1'b0, aux_oe);
      // Divided and external count clocks over 16 edges, a whole number of divider periods
      do_reset(2);
      @(posedge clk_sys);
      psc_sel <= {3'h4, TSP_PSC_SYS, TSP_PSC_DIV8, TSP_PSC_DIV4, TSP_PSC_DIV2};
      edge_sel <= 10'h200;
      io_a[7:6] <= TSP_IO_ONE;
      start_bits <= 5'h1F;
      // External pin 0 rises twice and falls once inside the window, after the three-stage delay
      for (int k = 0; k < 16; k++) begin
         @(posedge clk_sys);
         ext_clk[0] <= ((k & 4) == 0);
      end
      start_bits <= 5'h00;
      @(negedge clk_sys);
      chk16("div2 count", 16'h0008, cnt_of(0));
      chk16("div4 count", 16'h0004, cnt_of(1));
      chk16("div8 count", 16'h0002, cnt_of(2));
      chk16("sys count", 16'h0010, cnt_of(3));
      chk16("ext both count", 16'h0003, cnt_of(4));
      chk1("compare pin a", 1'b1, pin_a[3]);
      chk1("idle pin a enable", 1'b0, pin_a_oe[2]);
      chk1("compare pin a enable", 1'b1, pin_a_oe[3]);
      complete_run();
   end
endmodule

// ===== tsp_ch_if.sv
// Control and status bundle between the top and one timer channel
interface tsp_ch_if #(parameter int W = 16);
   logic tick;
   logic start;
   logic pwm;
   logic sync;
   logic isolate;
   logic force_clr_a;
   logic preset;
   logic sync_clr_in;
   logic [1:0] clr_src;
   logic [1:0] io_a;
   logic [1:0] io_b;
   logic [W-1:0] general_reg_a;
   logic [W-1:0] general_reg_b;
   logic [W-1:0] preset_val;
   logic [W-1:0] cnt;
   logic match_a;
   logic match_b;
   logic own_clr;
   logic pin_a;
   logic pin_b;
   modport ctl (output tick, start, pwm, sync, isolate, force_clr_a, preset, sync_clr_in, clr_src, io_a, io_b,
      general_reg_a, general_reg_b, preset_val, input cnt, match_a, match_b, own_clr, pin_a, pin_b);
   modport chan (input tick, start, pwm, sync, isolate, force_clr_a, preset, sync_clr_in, clr_src, io_a, io_b,
      general_reg_a, general_reg_b, preset_val, output cnt, match_a, match_b, own_clr, pin_a, pin_b);
endinterface

// ===== tsp_channel.sv
// One 16-bit timer channel: counter, compare matches, pin A and pin B logic
module tsp_channel
   import tsp_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   tsp_ch_if.chan ch
);
   tsp_ch_state_s st;
   tsp_ch_state_s next_st;
   logic match_a;
   logic match_b;
   logic clr_a_sel;
   logic own_clr;
   logic sync_clr;

   // Apply one compare output action to a pin level
   function automatic logic apply_io(input logic [1:0] code, input logic lvl);
      logic r;
      r = lvl;
      unique case (code)
         TSP_IO_HOLD: r = lvl;
         TSP_IO_ZERO: r = 1'b0;
         TSP_IO_ONE: r = 1'b1;
         TSP_IO_TOGGLE: r = ~lvl;
      endcase
      return r;
   endfunction

   // Match fires on the count pulse that leaves the matching value
   assign match_a = ch.tick && ch.start && !ch.isolate && (st.cnt == ch.general_reg_a);
   assign match_b = ch.tick && ch.start && !ch.isolate && (st.cnt == ch.general_reg_b);
   assign clr_a_sel = (ch.clr_src == TSP_CLR_GRA) || ch.force_clr_a;
   assign own_clr = (clr_a_sel && match_a) || ((ch.clr_src == TSP_CLR_GRB) && match_b);
   assign sync_clr = ch.sync && (ch.clr_src == TSP_CLR_SYNC) && ch.sync_clr_in;

   // Next state: preset beats clear beats count
   always_comb begin
      next_st = st;
      if (ch.preset) begin
         next_st.cnt = ch.preset_val;
      end else if (own_clr || sync_clr) begin
         next_st.cnt = TSP_CNT_RESET;
      end else if (ch.tick && ch.start) begin
         next_st.cnt = st.cnt + 16'h0001;
      end
      if (ch.pwm) begin
         // Equal registers give both matches together and no change
         if (match_a && !match_b) begin
            next_st.pin_a = 1'b1;
         end else if (match_b && !match_a) begin
            next_st.pin_a = 1'b0;
         end
      end else if (match_a) begin
         next_st.pin_a = apply_io(ch.io_a, st.pin_a);
      end
      if (match_b) begin
         next_st.pin_b = apply_io(ch.io_b, st.pin_b);
      end
   end

   // State register
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ch.cnt = st.cnt;
   assign ch.pin_a = st.pin_a;
   assign ch.pin_b = st.pin_b;
   assign ch.match_a = match_a;
   assign ch.match_b = match_b;
   assign ch.own_clr = own_clr;

   count_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      !ch.start && !ch.preset && !sync_clr |=> $stable(st.cnt))
      else $error("counter moved while halted");
   pwm_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      ch.pwm && match_a && (ch.general_reg_a != ch.general_reg_b) |=> st.pin_a)
      else $error("pwm pin not set on match a");
   pwm_equal_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      ch.pwm && match_a && (ch.general_reg_a == ch.general_reg_b) |=> $stable(st.pin_a))
      else $error("pwm pin changed with equal registers");
   match_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      (ch.clr_src == TSP_CLR_GRB) && ch.tick && ch.start && !ch.isolate && (st.cnt == ch.general_reg_b) && !ch.preset
      |=> st.cnt == TSP_CNT_RESET)
      else $error("counter not cleared on match b");
   pin_b_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      ch.pwm && match_b && (ch.io_b == TSP_IO_ZERO) |=> !st.pin_b)
      else $error("pin b ignored its action in pwm mode");
endmodule

// ===== tsp_pkg.sv
// Shared constants and state types for the synchronized and PWM timer block
package tsp_pkg;
   localparam int TSP_NUM_CH = 5;
   localparam int TSP_CW = 16;
   localparam int TSP_CH_A = 3;
   localparam int TSP_CH_B = 4;
   // Counter clear source codes
   localparam logic [1:0] TSP_CLR_NONE = 2'h0;
   localparam logic [1:0] TSP_CLR_GRA = 2'h1;
   localparam logic [1:0] TSP_CLR_GRB = 2'h2;
   localparam logic [1:0] TSP_CLR_SYNC = 2'h3;
   // Compare output action codes
   localparam logic [1:0] TSP_IO_HOLD = 2'h0;
   localparam logic [1:0] TSP_IO_ZERO = 2'h1;
   localparam logic [1:0] TSP_IO_ONE = 2'h2;
   localparam logic [1:0] TSP_IO_TOGGLE = 2'h3;
   // Count clock select codes; bit 2 set picks external pin 0..3
   localparam logic [2:0] TSP_PSC_SYS = 3'h0;
   localparam logic [2:0] TSP_PSC_DIV2 = 3'h1;
   localparam logic [2:0] TSP_PSC_DIV4 = 3'h2;
   localparam logic [2:0] TSP_PSC_DIV8 = 3'h3;
   localparam logic [1:0] TSP_EDGE_RISE = 2'h0;
   localparam logic [1:0] TSP_EDGE_FALL = 2'h1;
   // Combined mode code selecting reset-synchronized PWM
   localparam logic [1:0] TSP_COMBO_RSYNC = 2'h1;
   localparam logic [TSP_CW-1:0] TSP_CNT_RESET = 16'h0000;
   localparam logic [2:0] TSP_PSC_RESET = 3'h0;
   localparam int TSP_NUM_EXT = 4;

   typedef struct packed {
      logic [TSP_CW-1:0] cnt;
      logic pin_a;
      logic pin_b;
   } tsp_ch_state_s;

   typedef struct packed {
      logic [2:0] psc;
      logic [TSP_NUM_EXT-1:0] ext_s1;
      logic [TSP_NUM_EXT-1:0] ext_s2;
      logic [TSP_NUM_EXT-1:0] ext_s3;
      logic [TSP_NUM_EXT-1:0] ext_lvl;
      logic rsync;
      logic [2:0] rs_out;
   } tsp_top_state_s;
endpackage

// ===== tsp_top.sv
// Five-channel timer with synchronizing, PWM and reset-synchronized PWM modes
module tsp_top
   import tsp_pkg::*;
#(
   parameter int NUM_CH = TSP_NUM_CH,
   parameter int CW = TSP_CW
) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [NUM_CH-1:0] i_start_bits,
   input wire logic [NUM_CH-1:0] i_sync_select_reg,
   input wire logic [NUM_CH-1:0] i_timer_mode_pwm,
   input wire logic [2*NUM_CH-1:0] i_clear_source_field,
   input wire logic [3*NUM_CH-1:0] i_clock_prescale_select,
   input wire logic [2*NUM_CH-1:0] i_ext_edge_select,
   input wire logic [2*NUM_CH-1:0] i_pin_a_io_field,
   input wire logic [2*NUM_CH-1:0] i_pin_b_io_field,
   input wire logic [CW*NUM_CH-1:0] i_general_reg_a,
   input wire logic [CW*NUM_CH-1:0] i_general_reg_b,
   input wire logic [NUM_CH-1:0] i_count_wr,
   input wire logic [CW-1:0] i_count_wdata,
   input wire logic [1:0] i_combo_mode_field,
   input wire logic [TSP_NUM_EXT-1:0] i_ext_clk,
   output logic [NUM_CH-1:0] o_chan_pin_a,
   output logic [NUM_CH-1:0] o_chan_pin_a_oe,
   output logic [NUM_CH-1:0] o_chan_pin_b,
   output logic [NUM_CH-1:0] o_chan_pin_b_oe,
   output logic o_aux_out_a4,
   output logic o_aux_out_b4,
   output logic o_aux_oe,
   output logic [CW*NUM_CH-1:0] o_timer_count,
   output logic o_rsync_active
);
   tsp_top_state_s st;
   tsp_top_state_s next_st;
   logic [TSP_NUM_EXT-1:0] ext_rise;
   logic [TSP_NUM_EXT-1:0] ext_fall;
   logic [NUM_CH-1:0] own_clr_vec;
   logic [NUM_CH-1:0] tick_vec;
   logic [NUM_CH-1:0] pin_a_vec;
   logic [NUM_CH-1:0] pin_b_vec;
   logic sync_clr_any;
   logic sync_wr_any;
   logic tp1;
   logic tp2;
   logic [2:0] rs_toggle;

   tsp_ch_if #(.W(CW)) ch_bus[NUM_CH]();

   // Settled level changes only once stages two and three agree
   always_comb begin
      for (int j = 0; j < TSP_NUM_EXT; j++) begin
         ext_rise[j] = (st.ext_s2[j] == st.ext_s3[j]) && st.ext_s3[j] && !st.ext_lvl[j];
         ext_fall[j] = (st.ext_s2[j] == st.ext_s3[j]) && !st.ext_s3[j] && st.ext_lvl[j];
      end
   end

   assign sync_clr_any = |(own_clr_vec & i_sync_select_reg);
   assign sync_wr_any = |(i_count_wr & i_sync_select_reg);

   // Per-channel clock select, preset fan-out and mode overrides
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic [2:0] psel;
      logic [1:0] esel;
      logic [1:0] eidx;
      logic ext_tick;
      assign psel = i_clock_prescale_select[3*i +: 3];
      assign esel = i_ext_edge_select[2*i +: 2];
      assign eidx = psel[1:0];
      assign ext_tick = (esel == TSP_EDGE_RISE) ? ext_rise[eidx] :
         (esel == TSP_EDGE_FALL) ? ext_fall[eidx] : (ext_rise[eidx] || ext_fall[eidx]);
      // Divided rates are single-cycle enables from one free divider
      always_comb begin
         unique case (psel)
            TSP_PSC_SYS: tick_vec[i] = 1'b1;
            TSP_PSC_DIV2: tick_vec[i] = st.psc[0];
            TSP_PSC_DIV4: tick_vec[i] = &st.psc[1:0];
            TSP_PSC_DIV8: tick_vec[i] = &st.psc;
            default: tick_vec[i] = ext_tick;
         endcase
      end
      assign ch_bus[i].tick = tick_vec[i];
      assign ch_bus[i].start = i_start_bits[i];
      assign ch_bus[i].pwm = i_timer_mode_pwm[i];
      assign ch_bus[i].sync = i_sync_select_reg[i];
      assign ch_bus[i].isolate = st.rsync && (i == TSP_CH_B);
      assign ch_bus[i].force_clr_a = st.rsync && (i == TSP_CH_A);
      assign ch_bus[i].preset = i_count_wr[i] || (i_sync_select_reg[i] && sync_wr_any);
      assign ch_bus[i].preset_val = i_count_wdata;
      assign ch_bus[i].sync_clr_in = sync_clr_any;
      assign ch_bus[i].clr_src = i_clear_source_field[2*i +: 2];
      assign ch_bus[i].io_a = i_pin_a_io_field[2*i +: 2];
      assign ch_bus[i].io_b = i_pin_b_io_field[2*i +: 2];
      assign ch_bus[i].general_reg_a = i_general_reg_a[CW*i +: CW];
      assign ch_bus[i].general_reg_b = i_general_reg_b[CW*i +: CW];
      assign own_clr_vec[i] = ch_bus[i].own_clr;
      assign pin_a_vec[i] = ch_bus[i].pin_a;
      assign pin_b_vec[i] = ch_bus[i].pin_b;
      assign o_timer_count[CW*i +: CW] = ch_bus[i].cnt;
      tsp_channel tsp_channel_inst (
         .i_clk_sys(i_clk_sys),
         .i_reset_n(i_reset_n),
         .ch(ch_bus[i])
      );
   end

   // Turning points all compare against the channel 3 counter
   assign tp1 = tick_vec[TSP_CH_A] && i_start_bits[TSP_CH_A] &&
      (ch_bus[TSP_CH_A].cnt == i_general_reg_a[CW*TSP_CH_B +: CW]);
   assign tp2 = tick_vec[TSP_CH_A] && i_start_bits[TSP_CH_A] &&
      (ch_bus[TSP_CH_A].cnt == i_general_reg_b[CW*TSP_CH_B +: CW]);
   assign rs_toggle = {tp2, tp1, ch_bus[TSP_CH_A].match_b} ^ {3{own_clr_vec[TSP_CH_A]}};

   // Synchronizers, divider, mode latch and paired output state
   always_comb begin
      next_st = st;
      next_st.psc = st.psc + 3'h1;
      next_st.ext_s1 = i_ext_clk;
      next_st.ext_s2 = st.ext_s1;
      next_st.ext_s3 = st.ext_s2;
      for (int j = 0; j < TSP_NUM_EXT; j++) begin
         if (st.ext_s2[j] == st.ext_s3[j]) begin
            next_st.ext_lvl[j] = st.ext_s3[j];
         end
      end
      // Mode change only honoured while channel 3 is halted
      if (!i_start_bits[TSP_CH_A]) begin
         next_st.rsync = (i_combo_mode_field == TSP_COMBO_RSYNC);
      end
      if (!st.rsync) begin
         next_st.rs_out = 3'h0;
      end else begin
         next_st.rs_out = st.rs_out ^ rs_toggle;
      end
   end

   // State register
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Reset-sync mode takes over all six channel 3 and 4 pins
   always_comb begin
      o_chan_pin_a = pin_a_vec;
      o_chan_pin_b = pin_b_vec;
      for (int i = 0; i < NUM_CH; i++) begin
         o_chan_pin_a_oe[i] = i_timer_mode_pwm[i] || (i_pin_a_io_field[2*i +: 2] != TSP_IO_HOLD);
         o_chan_pin_b_oe[i] = i_pin_b_io_field[2*i +: 2] != TSP_IO_HOLD;
      end
      o_aux_out_a4 = 1'b0;
      o_aux_out_b4 = 1'b0;
      o_aux_oe = st.rsync;
      if (st.rsync) begin
         o_chan_pin_a[TSP_CH_A] = st.rs_out[0];
         o_chan_pin_b[TSP_CH_A] = ~st.rs_out[0];
         o_chan_pin_a[TSP_CH_B] = st.rs_out[1];
         o_aux_out_a4 = ~st.rs_out[1];
         o_chan_pin_b[TSP_CH_B] = st.rs_out[2];
         o_aux_out_b4 = ~st.rs_out[2];
         o_chan_pin_a_oe[TSP_CH_A] = 1'b1;
         o_chan_pin_b_oe[TSP_CH_A] = 1'b1;
         o_chan_pin_a_oe[TSP_CH_B] = 1'b1;
         o_chan_pin_b_oe[TSP_CH_B] = 1'b1;
      end
   end
   assign o_rsync_active = st.rsync;

   sync_preset_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      sync_wr_any && i_sync_select_reg[0] && i_sync_select_reg[1]
      |=> ch_bus[0].cnt == ch_bus[1].cnt && ch_bus[0].cnt == $past(i_count_wdata))
      else $error("synchronized preset missed a channel");
   sync_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      own_clr_vec[0] && i_sync_select_reg[0] && i_sync_select_reg[1] &&
      (i_clear_source_field[3:2] == TSP_CLR_SYNC) && !ch_bus[1].preset |=> ch_bus[1].cnt == TSP_CNT_RESET)
      else $error("synchronized clear missed a channel");
   rsync_pair_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      st.rsync |-> (o_chan_pin_b[TSP_CH_A] != o_chan_pin_a[TSP_CH_A]) && (o_aux_out_b4 != o_chan_pin_b[TSP_CH_B]))
      else $error("reset-sync pair not complementary");
   rsync_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      st.rsync && ch_bus[TSP_CH_A].match_a && !ch_bus[TSP_CH_A].preset |=> ch_bus[TSP_CH_A].cnt == TSP_CNT_RESET)
      else $error("channel 3 not cleared at period match");
   rsync_toggle_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      st.rsync && $past(st.rsync) && tp1 && !own_clr_vec[TSP_CH_A] |=> st.rs_out[1] != $past(st.rs_out[1]))
      else $error("output pair two did not toggle");
   mode_halted_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      st.rsync != $past(st.rsync) |-> !$past(i_start_bits[TSP_CH_A]))
      else $error("mode changed while channel 3 ran");
endmodule
